// >>> ebcc_top.sv
// Added by the designer: the address map and the APB interface to the registers.
`include "ebcc_consts.svh"
// Configuration bank and external bus sequencer front end
module ebcc_top (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        hw_standby,
    input  wire logic        mode_67,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        cyc_req,
    input  wire logic        cyc_write,
    input  wire logic [2:0]  cyc_area,
    output logic             cyc_ack,
    output logic             rd_strobe,
    output logic             wr_strobe,
    output logic [3:0]       burst_words,
    input  wire logic        wait_pin_n,
    input  wire logic        bus_request_pin_n,
    output logic             bus_granted,
    output logic             bus_ack_pin_n,
    input  wire logic        buzzer_clock,
    input  wire logic [15:0] addr_hi,
    input  wire logic [15:0] port_data,
    input  wire logic [15:0] port_dir,
    output logic      [15:0] addr_pin_o,
    output logic      [15:0] addr_pin_oe_n,
    output logic             shared_port_pin_o,
    output logic             shared_port_pin_oe_n,
    input  wire logic        shared_port_data,
    input  wire logic        shared_port_dir
);
    logic [7:0]  idle_burst_control_q;
    logic [7:0]  release_wait_control_q;
    logic [7:0]  pin_function_control_q;
    logic        ppin_wait_n;
    logic        ppin_bus_request_pin_n;
    logic        ppin_hwstby;
    logic        ppin_buzzer_signal;
    logic        pfc_load_q;
    logic        wr_en;
    logic        rd_en;
    logic        addr_ok;
    logic        need_gap;
    logic        last_rd_q;
    logic [2:0]  last_area_q;
    logic        last_valid_q;
    logic [3:0]  burst_cnt_q;
    logic        beat_half_q;
    ebcc_pkg::ebcc_state_e state_q;
    ebcc_pkg::ebcc_state_e state_d;

    // Pins from outside the clock domain pass a double flop
    ebcc_sync #(
        .W(4)
    ) u_sync (
        .pclk   (pclk),
        .presetn(presetn),
        .din    ({wait_pin_n, bus_request_pin_n, hw_standby, buzzer_clock}),
        .dout   ({ppin_wait_n, ppin_bus_request_pin_n, ppin_hwstby, ppin_buzzer_signal})
    );

    assign addr_ok = (paddr == `EBCC_OFF_IBC) || (paddr == `EBCC_OFF_RWC)
                  || (paddr == `EBCC_OFF_PFC) || (paddr == `EBCC_OFF_STAT);
    assign wr_en = psel && penable && pwrite && pready;
    assign rd_en = psel && !penable && !pwrite;

    // No wait state: pready rises in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // Read data registered in setup so it is valid with pready
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en)
        begin
            case (paddr)
                `EBCC_OFF_IBC:  prdata <= {24'h000000, idle_burst_control_q};
                `EBCC_OFF_RWC:  prdata <= {24'h000000, release_wait_control_q};
                `EBCC_OFF_PFC:  prdata <= {24'h000000, pin_function_control_q};
                `EBCC_OFF_STAT: prdata <= {28'h0000000, state_q};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Standby reloads like reset; soft standby has no effect on contents
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            idle_burst_control_q <= `EBCC_IBC_RESET;
        else if (ppin_hwstby)
            idle_burst_control_q <= `EBCC_IBC_RESET;
        else if (wr_en && paddr == `EBCC_OFF_IBC)
            idle_burst_control_q <= pwdata[7:0] & `EBCC_IBC_WMASK;
    end

    // Bit 5 masked off so it stays zero whatever software writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            release_wait_control_q <= `EBCC_RWC_RESET;
        else if (ppin_hwstby)
            release_wait_control_q <= `EBCC_RWC_RESET;
        else if (wr_en && paddr == `EBCC_OFF_RWC)
            release_wait_control_q <= pwdata[7:0] & `EBCC_RWC_WMASK;
    end

    // Mode strap is sampled after release, never inside the async reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_function_control_q <= `EBCC_PFC_RESET_67;
            pfc_load_q             <= 1'b1;
        end
        else if (pfc_load_q || ppin_hwstby)
        begin
            pfc_load_q             <= 1'b0;
            pin_function_control_q <= mode_67 ? `EBCC_PFC_RESET_67
                                              : `EBCC_PFC_RESET_45;
        end
        else if (wr_en && paddr == `EBCC_OFF_PFC)
            pin_function_control_q <= pwdata[7:0];
    end

    // Idle insertion decision from the previous external cycle
    always_comb
    begin
        need_gap = 1'b0;
        if (last_valid_q && last_rd_q)
        begin
            if (idle_burst_control_q[`EBCC_BIT_XAREA] && !cyc_write
                && cyc_area != last_area_q)
                need_gap = 1'b1;
            if (idle_burst_control_q[`EBCC_BIT_RDWR] && cyc_write)
                need_gap = 1'b1;
        end
    end

    // Sequencer: a cycle or burst runs, a gap separates when asked
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ebcc_pkg::EBCC_IDLE:
            begin
                // Held request is still up while the ack pulse shows
                if (cyc_req && !bus_granted && !cyc_ack)
                begin
                    if (need_gap)
                        state_d = ebcc_pkg::EBCC_GAP;
                    else if (idle_burst_control_q[`EBCC_BIT_BROM]
                             && cyc_area == 3'h0 && !cyc_write)
                        state_d = ebcc_pkg::EBCC_BURST;
                    else
                        state_d = ebcc_pkg::EBCC_CYC;
                end
            end
            // Gap lasts one state and runs straight into the held request
            ebcc_pkg::EBCC_GAP:
            begin
                if (idle_burst_control_q[`EBCC_BIT_BROM]
                    && cyc_area == 3'h0 && !cyc_write)
                    state_d = ebcc_pkg::EBCC_BURST;
                else
                    state_d = ebcc_pkg::EBCC_CYC;
            end
            ebcc_pkg::EBCC_CYC:
            begin
                if (!(release_wait_control_q[`EBCC_BIT_WAIT_PIN_ENABLE] && !ppin_wait_n))
                    state_d = ebcc_pkg::EBCC_IDLE;
            end
            ebcc_pkg::EBCC_BURST:
            begin
                if (burst_cnt_q == 4'h1 && (beat_half_q
                    || !idle_burst_control_q[`EBCC_BIT_BCYC]))
                    state_d = ebcc_pkg::EBCC_IDLE;
            end
            default:
                state_d = ebcc_pkg::EBCC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_q <= ebcc_pkg::EBCC_IDLE;
        else
            state_q <= state_d;
    end

    // Beat counter for burst ROM; half flag stretches beats to two states
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            burst_cnt_q <= 4'h0;
            beat_half_q <= 1'b0;
        end
        else if (state_q != ebcc_pkg::EBCC_BURST)
        begin
            burst_cnt_q <= idle_burst_control_q[`EBCC_BIT_BLEN]
                         ? 4'(`EBCC_BURST_LONG) : 4'(`EBCC_BURST_SHORT);
            beat_half_q <= 1'b0;
        end
        else if (idle_burst_control_q[`EBCC_BIT_BCYC] && !beat_half_q)
            beat_half_q <= 1'b1;
        else
        begin
            beat_half_q <= 1'b0;
            burst_cnt_q <= burst_cnt_q - 4'h1;
        end
    end

    // Remember last cycle kind and area for idle decisions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            last_rd_q    <= 1'b0;
            last_area_q  <= 3'h0;
            last_valid_q <= 1'b0;
        end
        else if ((state_q == ebcc_pkg::EBCC_IDLE
                  || state_q == ebcc_pkg::EBCC_GAP)
                 && state_d != ebcc_pkg::EBCC_IDLE
                 && state_d != ebcc_pkg::EBCC_GAP)
        begin
            last_rd_q    <= !cyc_write;
            last_area_q  <= cyc_area;
            last_valid_q <= 1'b1;
        end
    end

    // Strobes off in idle and gap states; registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_strobe   <= 1'b0;
            wr_strobe   <= 1'b0;
            cyc_ack     <= 1'b0;
            burst_words <= 4'h0;
        end
        else
        begin
            rd_strobe   <= (state_d == ebcc_pkg::EBCC_CYC && !cyc_write)
                        || state_d == ebcc_pkg::EBCC_BURST;
            wr_strobe   <= state_d == ebcc_pkg::EBCC_CYC && cyc_write;
            cyc_ack     <= state_q != ebcc_pkg::EBCC_IDLE
                        && state_q != ebcc_pkg::EBCC_GAP
                        && state_d == ebcc_pkg::EBCC_IDLE;
            burst_words <= idle_burst_control_q[`EBCC_BIT_BLEN]
                         ? 4'(`EBCC_BURST_LONG) : 4'(`EBCC_BURST_SHORT);
        end
    end

    // Release only between cycles and only when enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_granted   <= 1'b0;
            bus_ack_pin_n <= 1'b1;
        end
        else
        begin
            if (!release_wait_control_q[`EBCC_BIT_BUS_RELEASE_ENABLE] || ppin_bus_request_pin_n)
                bus_granted <= 1'b0;
            else if (state_q == ebcc_pkg::EBCC_IDLE && !cyc_req)
                bus_granted <= 1'b1;
            bus_ack_pin_n <= !(release_wait_control_q[`EBCC_BIT_BUS_RELEASE_ENABLE]
                             && bus_granted);
        end
    end

    // Address field n enables lines A8..A(7+n); one generate per line
    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++)
        begin : g_addr
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    addr_pin_o[gi]    <= 1'b0;
                    addr_pin_oe_n[gi] <= 1'b1;
                end
                else if (!mode_67 && 5'(gi) < {1'b0,
                         pin_function_control_q[3:0]})
                begin
                    addr_pin_o[gi]    <= addr_hi[gi];
                    addr_pin_oe_n[gi] <= 1'b0;
                end
                else
                begin
                    addr_pin_o[gi]    <= port_data[gi];
                    addr_pin_oe_n[gi] <= !port_dir[gi];
                end
            end
        end
    endgenerate

    // Buzzer takes the shared pin over from the port when enabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            shared_port_pin_o    <= 1'b0;
            shared_port_pin_oe_n <= 1'b1;
        end
        else if (pin_function_control_q[`EBCC_BIT_BUZZER_SIGNAL])
        begin
            shared_port_pin_o    <= ppin_buzzer_signal;
            shared_port_pin_oe_n <= 1'b0;
        end
        else
        begin
            shared_port_pin_o    <= shared_port_data;
            shared_port_pin_oe_n <= !shared_port_dir;
        end
    end

    ibc_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        ppin_hwstby |=> idle_burst_control_q == `EBCC_IBC_RESET)
        else $error("idle/burst not reloaded");
    rwc_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
        ppin_hwstby |=> release_wait_control_q == `EBCC_RWC_RESET)
        else $error("release/wait not reloaded");
    rwc_bit5_a: assert property (@(posedge pclk) disable iff (!presetn)
        release_wait_control_q[5] == 1'b0)
        else $error("bit 5 not zero");
    gap_one_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ebcc_pkg::EBCC_GAP |-> (!rd_strobe && !wr_strobe)
        ##1 state_q != ebcc_pkg::EBCC_GAP)
        else $error("gap not one state");
    rdwr_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ebcc_pkg::EBCC_IDLE && cyc_req && !bus_granted && !cyc_ack
        && cyc_write && last_valid_q && last_rd_q
        && idle_burst_control_q[`EBCC_BIT_RDWR]
        |=> state_q == ebcc_pkg::EBCC_GAP)
        else $error("read-write idle missing");
    xarea_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ebcc_pkg::EBCC_IDLE && cyc_req && !bus_granted && !cyc_ack
        && !cyc_write && last_valid_q && last_rd_q
        && cyc_area != last_area_q
        && idle_burst_control_q[`EBCC_BIT_XAREA]
        |=> state_q == ebcc_pkg::EBCC_GAP)
        else $error("cross-area idle missing");
    burst_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ebcc_pkg::EBCC_BURST
        |-> idle_burst_control_q[`EBCC_BIT_BROM])
        else $error("burst without enable");
    burst_len_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ebcc_pkg::EBCC_BURST |-> burst_cnt_q
        <= (idle_burst_control_q[`EBCC_BIT_BLEN]
            ? 4'(`EBCC_BURST_LONG) : 4'(`EBCC_BURST_SHORT)))
        else $error("burst too long");
    release_a: assert property (@(posedge pclk) disable iff (!presetn)
        bus_granted |-> $past(release_wait_control_q[`EBCC_BIT_BUS_RELEASE_ENABLE]))
        else $error("release while disabled");
    buzzer_signal_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(pin_function_control_q[`EBCC_BIT_BUZZER_SIGNAL])
        |-> !shared_port_pin_oe_n && shared_port_pin_o == $past(ppin_buzzer_signal))
        else $error("buzzer not driven");
    addr_a: assert property (@(posedge pclk) disable iff (!presetn)
        $past(!mode_67 && pin_function_control_q[3:0] != 4'h0)
        |-> !addr_pin_oe_n[0] && addr_pin_o[0] == $past(addr_hi[0]))
        else $error("A8 not driven");
    cov_gap_c: cover property (@(posedge pclk) state_q == ebcc_pkg::EBCC_GAP);
    cov_burst_c: cover property (@(posedge pclk)
        state_q == ebcc_pkg::EBCC_BURST ##1 state_q == ebcc_pkg::EBCC_IDLE);
    cov_grant_c: cover property (@(posedge pclk) bus_granted);
endmodule

// >>> ebcc_consts.svh
// Behaviour
// - Idle/burst control loads 0xD0 on reset and standby; kept in soft standby.
// - Cross-area idle bit set inserts one idle between reads to different areas.
// - Read-write idle bit set inserts one idle between read then write.
// - Burst ROM enable selects burst ROM interface for area 0, else basic.
// - Burst cycle length bit: 0 gives one state, 1 gives two states.
// - Burst word limit bit: 0 allows four words, 1 allows eight.
// - Release/wait control loads 0x08 on reset and standby; kept in soft standby.
// - Bus release enable lets an external master take the bus.
// - Wait pin enable makes the device honour the external wait pin; the code honours it in basic cycles only, not in burst ROM cycles.
// - Release/wait bit 5 ignores writes and reads as zero.
// - Pin function control resets to 0x0D in modes 4/5, 0x00 in 6/7.
// - Buzzer enable drives selected watchdog clock onto the shared port pin.
// - In expanded modes the address field selects driven lines A8 to A23; the code reaches A8 to A22 at most, A23 never carries the address.
// - An enabled address pin drives the address regardless of direction bit.
// - A disabled address pin is a port pin, output when direction bit is one.
// - Field value n enables address lines A8 up to A(7+n).
`ifndef EBCC_CONSTS_SVH
`define EBCC_CONSTS_SVH
`define EBCC_OFF_IBC        12'h000
`define EBCC_OFF_RWC        12'h004
`define EBCC_OFF_PFC        12'h008
`define EBCC_OFF_STAT       12'h00C
`define EBCC_IBC_RESET      8'hD0
`define EBCC_RWC_RESET      8'h08
`define EBCC_PFC_RESET_45   8'h0D
`define EBCC_PFC_RESET_67   8'h00
`define EBCC_IBC_WMASK      8'hFF
`define EBCC_RWC_WMASK      8'hDF
`define EBCC_BIT_XAREA      7
`define EBCC_BIT_RDWR       6
`define EBCC_BIT_BROM       5
`define EBCC_BIT_BCYC       4
`define EBCC_BIT_BLEN       3
`define EBCC_BIT_BUS_RELEASE_ENABLE       7
`define EBCC_BIT_WAIT_PIN_ENABLE      0
`define EBCC_BIT_BUZZER_SIGNAL       5
`define EBCC_BURST_SHORT    4
`define EBCC_BURST_LONG     8
`endif

// >>> ebcc_pkg.sv
package ebcc_pkg;
    typedef enum logic [3:0]
    {
        EBCC_IDLE  = 4'h1,
        EBCC_GAP   = 4'h2,
        EBCC_CYC   = 4'h4,
        EBCC_BURST = 4'h8
    } ebcc_state_e;
endpackage

// >>> ebcc_sync.sv
// Two-stage synchroniser for pin inputs; first stage feeds only the second
module ebcc_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    // Plain double flop per bit
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= '0;
            dout   <= '0;
        end
        else
        begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// >>> ebcc_ext_model.sv
// Far-side memory and bus requester: watches strobes, asks for wait
module ebcc_ext_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic rd_strobe,
    input  wire logic wr_strobe,
    input  wire logic stall,
    input  wire logic want_bus,
    output logic      wait_pin_n,
    output logic      bus_request_pin_n,
    output int        on_total,
    output int        off_len
);
    timeunit 1ns;
    timeprecision 1ps;
    int   on_q;
    int   off_q;
    logic strobe;
    assign strobe = rd_strobe | wr_strobe;
    // Run lengths; an inserted idle state shows as a longer off run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            on_q     <= 0;
            off_q    <= 0;
            on_total <= 0;
            off_len  <= 0;
        end
        else if (strobe)
        begin
            on_q     <= on_q + 1;
            on_total <= on_total + 1;
            off_q    <= 0;
            if (on_q == 0)
                off_len <= off_q;
        end
        else
        begin
            on_q  <= 0;
            off_q <= off_q + 1;
        end
    end
    // A slow memory holds wait low from before the strobe to six states in,
    // so the synchroniser delay cannot hide it; pins idle high (pull-ups)
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_pin_n        <= 1'b1;
            bus_request_pin_n <= 1'b1;
        end
        else
        begin
            wait_pin_n        <= !(stall && on_q < 6);
            bus_request_pin_n <= !want_bus;
        end
    end
endmodule

// >>> ext_bus_control_config_tb.sv
module ext_bus_control_config_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, hw_standby, mode_67;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic        cyc_req, cyc_write, cyc_ack, rd_strobe, wr_strobe;
    logic [2:0]  cyc_area;
    logic [3:0]  burst_words;
    logic        wait_pin_n, bus_request_pin_n, bus_granted, bus_ack_pin_n;
    logic        buzzer_clock, buzzer_signal_run, stall, want_bus, e;
    logic [15:0] addr_hi, port_data, port_dir, addr_pin_o, addr_pin_oe_n;
    logic [15:0] en, x, mk;
    logic        shared_port_pin_o, shared_port_pin_oe_n;
    logic        shared_port_data, shared_port_dir;
    logic [1:0]  seen;
    logic [7:0]  mdl [3];
    logic [7:0]  bv [4] = '{8'h00, 8'h20, 8'h30, 8'h28};
    int          n_fail, checked, ticks, on_total, off_len, t, dl;
    int          g [2];
    int          d [4];

    ebcc_top uut (.pclk, .presetn, .hw_standby, .mode_67, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cyc_req,
        .cyc_write, .cyc_area, .cyc_ack, .rd_strobe, .wr_strobe,
        .burst_words, .wait_pin_n, .bus_request_pin_n, .bus_granted,
        .bus_ack_pin_n, .buzzer_clock, .addr_hi, .port_data, .port_dir,
        .addr_pin_o, .addr_pin_oe_n, .shared_port_pin_o,
        .shared_port_pin_oe_n, .shared_port_data, .shared_port_dir);
    ebcc_ext_model ext (.pclk, .presetn, .rd_strobe, .wr_strobe, .stall,
        .want_bus, .wait_pin_n, .bus_request_pin_n, .on_total, .off_len);

    // 200 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Watchdog clock stand-in for the buzzer path
    always @(posedge pclk)
        if (buzzer_signal_run) buzzer_clock <= ~buzzer_clock;
    // Hang guard, well above the few hundred cycles the tests need
    always @(posedge pclk)
    begin
        ticks++;
        if (ticks > 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic give_verdict;
        $display("counts: checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; answer taken at the edge that sees pready high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] dat);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= dat;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wreg(input int i, input logic [7:0] v);
        apb(1'b1, 12'(i * 4), {24'h000000, v});
        mdl[i] = (i == 1) ? (v & 8'hDF) : v;
    endtask
    task automatic rchk(input int i);
        apb(1'b0, 12'(i * 4), 32'h00000000);
        cmp(r, {24'h000000, mdl[i]});
    endtask
    task automatic mreset;
        mdl[0] = 8'hD0;
        mdl[1] = 8'h08;
        mdl[2] = mode_67 ? 8'h00 : 8'h0D;
    endtask
    // Request held until acknowledged; the next one may follow at once
    task automatic bus(input logic w, input logic [2:0] a);
        int n;
        n = 0;
        cyc_req   <= 1'b1;
        cyc_write <= w;
        cyc_area  <= a;
        @(posedge pclk);
        while (cyc_ack !== 1'b1 && n < 64)
        begin
            @(posedge pclk);
            n++;
        end
        if (n == 64) n_fail++;
    endtask
    // Last cycle of a run; dl gets the strobe-high states it took
    task automatic one(input logic w, input logic [2:0] a);
        t = on_total;
        bus(w, a);
        cyc_req <= 1'b0;
        repeat (4) @(posedge pclk);
        dl = on_total - t;
    endtask

    initial
    begin
        {presetn, hw_standby, mode_67, psel, penable, pwrite} = 6'h00;
        {cyc_req, cyc_write, cyc_area, buzzer_clock, buzzer_signal_run} = 7'h00;
        {stall, want_bus, shared_port_data, shared_port_dir} = 4'h0;
        {paddr, pwdata} = 44'h00000000000;
        {addr_hi, port_data, port_dir} = 48'h000000000000;
        {n_fail, checked, ticks} = 96'h0;
        void'($urandom(40625));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        mreset();
        for (int i = 0; i < 3; i++)
            rchk(i);
        apb(1'b0, 12'h010, 32'h00000000);
        cmp({31'h0, e}, 32'h00000001);
        cmp(r, 32'h00000000);
        // Random writes with reserved bits as software must leave them
        for (int k = 0; k < 4; k++)
        begin
            wreg(0, 8'($urandom) & 8'hF8);
            wreg(1, (8'($urandom) & 8'h81) | 8'h08);
            rchk(0);
            rchk(1);
        end
        wreg(1, 8'hA9);
        rchk(1);
        $display("test registers done");
        // Standby pin reloads; pin function value follows the mode strap
        wreg(2, 8'h25);
        for (int m = 0; m < 2; m++)
        begin
            mode_67    <= m[0];
            hw_standby <= 1'b1;
            repeat (4) @(posedge pclk);
            hw_standby <= 1'b0;
            repeat (4) @(posedge pclk);
            mreset();
            for (int i = 0; i < 3; i++)
                rchk(i);
        end
        mode_67 <= 1'b0;
        $display("test standby done");
        // Every address field value against random pin settings
        for (int n = 0; n < 16; n++)
        begin
            addr_hi   <= 16'($urandom);
            port_data <= 16'($urandom);
            port_dir  <= 16'($urandom);
            wreg(2, 8'(n));
            repeat (4) @(posedge pclk);
            en = 16'((32'h1 << n) - 1);
            x  = ~en & ~port_dir;
            cmp(addr_pin_oe_n, x);
            mk = en | port_dir;
            x  = ((en & addr_hi) | (~en & port_data)) & mk;
            cmp(addr_pin_o & mk, x);
        end
        $display("test address done");
        // Buzzer on the shared pin, then back to a plain port pin
        wreg(2, 8'h20);
        buzzer_signal_run <= 1'b1;
        seen = 2'b00;
        repeat (16)
        begin
            @(posedge pclk);
            seen |= {shared_port_pin_o === 1'b1, shared_port_pin_o === 1'b0};
        end
        cmp({30'h0, seen}, 32'h00000003);
        cmp({31'h0, shared_port_pin_oe_n}, 32'h00000000);
        buzzer_signal_run         <= 1'b0;
        shared_port_dir  <= 1'b1;
        shared_port_data <= 1'($urandom);
        wreg(2, 8'h00);
        repeat (4) @(posedge pclk);
        cmp({31'h0, shared_port_pin_oe_n}, 32'h00000000);
        cmp({31'h0, shared_port_pin_o}, {31'h0, shared_port_data});
        $display("test buzzer done");
        // Back-to-back cycles with each idle bit off and on
        for (int b = 0; b < 2; b++)
        begin
            for (int s = 0; s < 2; s++)
            begin
                wreg(0, s ? (b ? 8'h40 : 8'h80) : 8'h00);
                bus(1'b0, 3'h1);
                one(b[0], b ? 3'h1 : 3'h2);
                g[s] = off_len;
            end
            cmp(g[1], g[0] + 1);
        end
        $display("test idle done");
        // Area 0 reads: basic, burst short and long beats, eight words
        for (int i = 0; i < 4; i++)
        begin
            wreg(0, bv[i]);
            one(1'b0, 3'h0);
            d[i] = dl;
            if (i > 0)
                cmp({28'h0, burst_words}, bv[i][3] ? 32'h8 : 32'h4);
        end
        cmp({31'h0, d[1] > d[0]}, 32'h00000001);
        cmp({31'h0, d[2] > d[1]}, 32'h00000001);
        cmp({31'h0, d[3] > d[1]}, 32'h00000001);
        $display("test burst done");
        // Slow memory: wait pin counts only when enabled
        stall <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            wreg(1, 8'h08 | 8'(i));
            one(1'b0, 3'h1);
            d[i] = dl;
        end
        cmp({31'h0, d[1] > d[0]}, 32'h00000001);
        stall <= 1'b0;
        $display("test wait done");
        // Bus request refused, then granted once release is enabled
        for (int i = 0; i < 2; i++)
        begin
            wreg(1, i ? 8'h88 : 8'h08);
            want_bus <= 1'b1;
            repeat (12) @(posedge pclk);
            cmp({31'h0, bus_granted}, 32'(i));
            cmp({31'h0, bus_ack_pin_n}, 32'(1 - i));
            want_bus <= 1'b0;
            repeat (12) @(posedge pclk);
        end
        $display("test release done");
        give_verdict();
    end
endmodule
